/* File: rtl/smac_pkg.sv */
// Package with encodings, field positions and constants of the multiply-accumulate unit.
package smac_pkg;
  localparam logic [6:0] SMAC_OPCODE      = 7'h7B;
  localparam logic [2:0] SMAC_FUNCT3      = 3'h0;
  localparam logic [6:0] SMAC_F7_DUAL_TT  = 7'h6E;
  localparam logic [6:0] SMAC_F7_SAT_LL   = 7'h6F;
  localparam logic [6:0] SMAC_F7_SAT_LH   = 7'h70;
  localparam logic [6:0] SMAC_F7_SAT_HH   = 7'h71;
  localparam int         SMAC_OPC_LSB     = 0;
  localparam int         SMAC_RD_LSB      = 7;
  localparam int         SMAC_F3_LSB      = 12;
  localparam int         SMAC_RS1_LSB     = 15;
  localparam int         SMAC_RS2_LSB     = 20;
  localparam int         SMAC_F7_LSB      = 25;
  localparam logic [63:0] SMAC_SAT_MAX    = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] SMAC_SAT_MIN    = 64'h8000_0000_0000_0000;
  localparam logic       SMAC_OV_RESET    = 1'b0;

  typedef enum logic [3:0] {
    SMAC_OP_DUAL_TT = 4'h1,
    SMAC_OP_SAT_LL  = 4'h2,
    SMAC_OP_SAT_LH  = 4'h4,
    SMAC_OP_SAT_HH  = 4'h8
  } smac_op_t;
endpackage

/* File: rtl/smac_decode.sv */
// Instruction decoder for the multiply-accumulate unit.
`timescale 1ns/1ps
`default_nettype none
module smac_decode
  import smac_pkg::*;
(
  // Instruction
  input  wire logic [31:0] instr,
  // Decode results
  output logic             hit,
  output var smac_op_t     op,
  output logic [4:0]       rd_idx,
  output logic [4:0]       rs1_idx,
  output logic [4:0]       rs2_idx
);
  wire logic [6:0] opc_w = instr[SMAC_OPC_LSB +: 7];
  wire logic [2:0] f3_w  = instr[SMAC_F3_LSB +: 3];
  wire logic [6:0] f7_w  = instr[SMAC_F7_LSB +: 7];
  wire logic       space_w = (opc_w == SMAC_OPCODE) && (f3_w == SMAC_FUNCT3);

  assign rd_idx  = instr[SMAC_RD_LSB +: 5];
  assign rs1_idx = instr[SMAC_RS1_LSB +: 5];
  assign rs2_idx = instr[SMAC_RS2_LSB +: 5];
  assign hit = space_w && ((f7_w == SMAC_F7_DUAL_TT) || (f7_w == SMAC_F7_SAT_LL) ||
                           (f7_w == SMAC_F7_SAT_LH) || (f7_w == SMAC_F7_SAT_HH));

  always_comb begin
    unique case (f7_w)
      SMAC_F7_SAT_LL: op = SMAC_OP_SAT_LL;
      SMAC_F7_SAT_LH: op = SMAC_OP_SAT_LH;
      SMAC_F7_SAT_HH: op = SMAC_OP_SAT_HH;
      default:        op = SMAC_OP_DUAL_TT;
    endcase
  end
endmodule // smac_decode
`default_nettype wire

/* File: rtl/smac_unit.sv */
// Packed multiply-accumulate execution unit with a one-cycle registered result.
`timescale 1ns/1ps
`default_nettype none
module smac_unit
  import smac_pkg::*;
#(
  parameter int XLEN = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Issue from the pipeline
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] rs1_val,
  input  wire logic [63:0] rs2_val,
  input  wire logic [63:0] acc_val,
  // Decode answer towards register read
  output logic             insn_hit,
  output logic [4:0]       rs1_idx,
  output logic [4:0]       rs2_idx,
  output logic [4:0]       acc_lo_idx,
  output logic [4:0]       acc_hi_idx,
  // Writeback
  output logic             wb_valid,
  output logic [4:0]       wb_lo_idx,
  output logic [4:0]       wb_hi_idx,
  output logic             wb_pair,
  output logic [63:0]      wb_data,
  // Status
  output logic             ov_set_pulse,
  output logic             overflow_sticky_flag,
  input  wire logic        ov_clear
);
  // Only a 32-bit base with register pairs or a 64-bit base is served.
  if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
    $error("XLEN must be 32 or 64");
  end

  smac_op_t   op_w;
  logic [4:0] rd_w;

  smac_decode u_dec (
    .instr   (instr),
    .hit     (insn_hit),
    .op      (op_w),
    .rd_idx  (rd_w),
    .rs1_idx (rs1_idx),
    .rs2_idx (rs2_idx)
  );

  // On RV32 the accumulator pair is the even register and the next odd one.
  wire logic        pair_w = (XLEN == 32);
  assign acc_lo_idx = pair_w ? {rd_w[4:1], 1'b0} : rd_w;
  assign acc_hi_idx = pair_w ? {rd_w[4:1], 1'b1} : rd_w;

  // Dual top-half products, each sign-extended to 64 bits.
  wire logic signed [31:0] tt0_w = $signed(rs1_val[31:16]) * $signed(rs2_val[31:16]);
  wire logic signed [31:0] tt1_w = $signed(rs1_val[63:48]) * $signed(rs2_val[63:48]);
  wire logic [63:0] dual_sum_w = acc_val + {{32{tt0_w[31]}}, tt0_w}
                                         + {{32{tt1_w[31]}}, tt1_w};

  // Word selection for the saturating modes.
  wire logic [31:0] a_w = (op_w == SMAC_OP_SAT_HH) ? rs1_val[63:32] : rs1_val[31:0];
  wire logic [31:0] b_w = (op_w == SMAC_OP_SAT_LL) ? rs2_val[31:0] : rs2_val[63:32];
  wire logic signed [63:0] prod_w = $signed(a_w) * $signed(b_w);
  wire logic signed [64:0] wide_w = $signed({acc_val[63], acc_val})
                                  + $signed({prod_w[63], prod_w});
  wire logic pos_ovf_w = (wide_w[64:63] == 2'b01);
  wire logic neg_ovf_w = (wide_w[64:63] == 2'b10);
  wire logic [63:0] sat_sum_w = pos_ovf_w ? SMAC_SAT_MAX :
                                neg_ovf_w ? SMAC_SAT_MIN : wide_w[63:0];
  wire logic is_sat_w = (op_w != SMAC_OP_DUAL_TT);
  wire logic fire_w   = issue_valid && insn_hit;
  wire logic clamp_w  = fire_w && is_sat_w && (pos_ovf_w || neg_ovf_w);

  logic        wb_valid_q;
  logic [4:0]  wb_lo_q;
  logic [4:0]  wb_hi_q;
  logic [63:0] wb_data_q;
  logic        ov_pulse_q;
  logic        ov_q;
  wire logic   ov_d = clamp_w ? 1'b1 : (ov_clear ? 1'b0 : ov_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_valid_q <= 1'b0;
      wb_lo_q    <= 5'h00;
      wb_hi_q    <= 5'h00;
      wb_data_q  <= 64'h0;
      ov_pulse_q <= 1'b0;
      ov_q       <= SMAC_OV_RESET;
    end else begin
      wb_valid_q <= fire_w;
      wb_lo_q    <= acc_lo_idx;
      wb_hi_q    <= acc_hi_idx;
      wb_data_q  <= is_sat_w ? sat_sum_w : dual_sum_w;
      ov_pulse_q <= clamp_w;
      ov_q       <= ov_d;
    end
  end

  assign wb_valid             = wb_valid_q;
  assign wb_lo_idx            = wb_lo_q;
  assign wb_hi_idx            = wb_hi_q;
  assign wb_pair              = pair_w;
  assign wb_data              = wb_data_q;
  assign ov_set_pulse         = ov_pulse_q;
  assign overflow_sticky_flag = ov_q;

  AST_CLAMP_SETS_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    clamp_w |=> overflow_sticky_flag && ov_set_pulse)
    else $error("clamp did not set overflow flag");

  AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    (!clamp_w && !ov_clear) |=> $stable(overflow_sticky_flag))
    else $error("overflow flag changed without cause");

  AST_WB_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
    fire_w |=> wb_valid)
    else $error("writeback missing after issue");

  AST_NO_SPURIOUS_WB: assert property (@(posedge clk) disable iff (!rst_b)
    !fire_w |=> !wb_valid)
    else $error("writeback without decoded issue");

  AST_DUAL_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && !is_sat_w) |=> wb_data == $past(dual_sum_w))
    else $error("dual accumulate result wrong");

  AST_SAT_MAX: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && is_sat_w && pos_ovf_w) |=> wb_data == SMAC_SAT_MAX)
    else $error("positive saturation wrong");

  AST_SAT_MIN: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && is_sat_w && neg_ovf_w) |=> wb_data == SMAC_SAT_MIN)
    else $error("negative saturation wrong");

  AST_PAIR_EVEN: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && pair_w) |=> !wb_lo_idx[0] && wb_hi_idx[0])
    else $error("register pair not even/odd");

  // Sequences for the issue kinds and for a clear without clamp that the checks below are built from.
  sequence s_sat_issue;
    fire_w && is_sat_w;
  endsequence

  sequence s_dual_issue;
    fire_w && !is_sat_w;
  endsequence

  sequence s_refused_issue;
    issue_valid && !insn_hit;
  endsequence

  sequence s_clear_only;
    ov_clear && !clamp_w;
  endsequence

  AST_PULSE_ONLY_ON_CLAMP: assert property (@(posedge clk) disable iff (!rst_b)
    !clamp_w |=> !ov_set_pulse)
    else $error("overflow pulse without clamp");

  AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rst_b)
    s_clear_only |=> !overflow_sticky_flag)
    else $error("overflow flag not cleared");

  AST_DUAL_NO_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    s_dual_issue |=> !ov_set_pulse)
    else $error("dual accumulate raised overflow");

  AST_REFUSED_NO_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    s_refused_issue |=> !ov_set_pulse && !wb_valid)
    else $error("unknown instruction had an effect");

  AST_SAT_IN_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
    s_sat_issue ##0 !(pos_ovf_w || neg_ovf_w) |=> wb_data == $past(acc_val) + $past(prod_w))
    else $error("unclamped saturating result wrong");

  AST_WB_INDEX: assert property (@(posedge clk) disable iff (!rst_b)
    fire_w |=> (wb_lo_idx == $past(acc_lo_idx)) && (wb_hi_idx == $past(acc_hi_idx)))
    else $error("writeback index wrong");

  AST_DECODE_SPACE: assert property (@(posedge clk) disable iff (!rst_b)
    insn_hit |-> (instr[6:0] == SMAC_OPCODE) && (instr[14:12] == SMAC_FUNCT3))
    else $error("hit outside opcode space");

  AST_SEL_LOW_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && op_w == SMAC_OP_SAT_LL) |-> (a_w == rs1_val[31:0]) && (b_w == rs2_val[31:0]))
    else $error("low-low word select wrong");

  AST_SEL_LOW_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && op_w == SMAC_OP_SAT_LH) |-> (a_w == rs1_val[31:0]) && (b_w == rs2_val[63:32]))
    else $error("low-high word select wrong");

  AST_SEL_HIGH_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    (fire_w && op_w == SMAC_OP_SAT_HH) |-> (a_w == rs1_val[63:32]) && (b_w == rs2_val[63:32]))
    else $error("high-high word select wrong");

  // Reset must leave no writeback and a clear flag behind it.
  AST_RESET_QUIET: assert property (@(posedge clk)
    !rst_b |=> !wb_valid && !ov_set_pulse && !overflow_sticky_flag)
    else $error("state not cleared by reset");
endmodule // smac_unit
`default_nettype wire

/* File: test/smac_core_model.sv */
// Pipeline writeback model that files results into an even/odd register pair.
`timescale 1ns/1ps
`default_nettype none
module smac_core_model (
  // Clock
  input  wire logic        clk,
  // Writeback from the unit
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_lo_idx,
  input  wire logic [4:0]  wb_hi_idx,
  input  wire logic [63:0] wb_data,
  // Register file image
  output logic [31:0]      gpr [32]
);
  always_ff @(posedge clk) begin
    if (wb_valid) begin
      gpr[wb_lo_idx] <= wb_data[31:0];
      gpr[wb_hi_idx] <= wb_data[63:32];
    end
  end
endmodule // smac_core_model
`default_nettype wire

/* File: test/test_smac_unit.sv */
// Self-checking testbench of the multiply-accumulate unit.
`timescale 1ns/1ps
`default_nettype none
module test_smac_unit;
  import smac_pkg::*;
  typedef struct packed {
    logic [6:0] f7;
    logic [63:0] a, b, c, r;
    logic h, p, f;
  } smac_row_t;
  logic clk = 1'b0, rst_b = 1'b0, issue_valid = 1'b0, ov_clear = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] rs1_val = 64'h0, rs2_val = 64'h0, acc_val = 64'h0;
  logic insn_hit, wb_valid, wb_pair, ov_set_pulse, overflow_sticky_flag;
  logic [4:0] rs1_idx, rs2_idx, acc_lo_idx, acc_hi_idx, wb_lo_idx, wb_hi_idx;
  logic [63:0] wb_data;
  logic [31:0] gpr [32];
  int err_total = 0, checks_done = 0;
  smac_row_t rows [9] = '{
    '{7'h6E, 64'h0002_0000_FFFF_0000, 64'h0003_0000_0005_0000, 64'h10, 64'h11, 1'b1, 1'b0, 1'b0},
    '{7'h6F, 64'h9_FFFF_FFFE, 64'h7_0000_0003, 64'h0, 64'hFFFF_FFFF_FFFF_FFFA, 1'b1, 1'b0, 1'b0},
    '{7'h70, 64'h9_0000_0002, 64'h7_0000_0005, 64'h1, 64'hF, 1'b1, 1'b0, 1'b0},
    '{7'h71, 64'h9_0000_0002, 64'h7_0000_0005, 64'h1, 64'h40, 1'b1, 1'b0, 1'b0},
    '{7'h6F, 64'h1, 64'h1, 64'h7FFF_FFFF_FFFF_FFFF, 64'h7FFF_FFFF_FFFF_FFFF, 1'b1, 1'b1, 1'b1},
    '{7'h71, 64'h1_0000_0000, 64'hFFFF_FFFF_0000_0000, SMAC_SAT_MIN, SMAC_SAT_MIN, 1'b1, 1'b1, 1'b1},
    '{7'h70, 64'h9_0000_0002, 64'h7_0000_0005, 64'h1, 64'hF, 1'b1, 1'b0, 1'b1},
    '{7'h6E, 64'h0002_0000_FFFF_0000, 64'h0003_0000_0005_0000, SMAC_SAT_MAX, SMAC_SAT_MIN, 1'b1, 1'b0, 1'b1},
    '{7'h6D, 64'h1, 64'h1, 64'h7FFF_FFFF_FFFF_FFFF, 64'h0, 1'b0, 1'b0, 1'b1}};
  smac_unit #(.XLEN(32)) DUT (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid), .instr(instr),
    .rs1_val(rs1_val), .rs2_val(rs2_val), .acc_val(acc_val), .insn_hit(insn_hit),
    .rs1_idx(rs1_idx), .rs2_idx(rs2_idx), .acc_lo_idx(acc_lo_idx), .acc_hi_idx(acc_hi_idx),
    .wb_valid(wb_valid), .wb_lo_idx(wb_lo_idx), .wb_hi_idx(wb_hi_idx), .wb_pair(wb_pair),
    .wb_data(wb_data), .ov_set_pulse(ov_set_pulse), .overflow_sticky_flag(overflow_sticky_flag),
    .ov_clear(ov_clear));
  smac_core_model u_core (.clk(clk), .wb_valid(wb_valid), .wb_lo_idx(wb_lo_idx),
    .wb_hi_idx(wb_hi_idx), .wb_data(wb_data), .gpr(gpr));
  always #10 clk = ~clk;
  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task run(input smac_row_t t);
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= {t.f7, 5'h3, 5'h2, SMAC_FUNCT3, 5'h6, SMAC_OPCODE};
    rs1_val <= t.a;
    rs2_val <= t.b;
    acc_val <= t.c;
    #1 chk("hit", insn_hit, t.h);
    chk("idx", {rs1_idx, rs2_idx, acc_lo_idx, acc_hi_idx}, 20'h10CC7);
    chk("wb_pair", wb_pair, 1'b1);
    @(posedge clk);
    issue_valid <= 1'b0;
    #1 chk("wb_valid", wb_valid, t.h);
    chk("pulse", ov_set_pulse, t.p);
    chk("flag", overflow_sticky_flag, t.f);
    if (t.h) chk("wb_data", wb_data, t.r);
    @(posedge clk);
    #1 chk("wb_valid low", wb_valid, 1'b0);
    if (t.h) chk("pair", {gpr[7], gpr[6]}, t.r);
    $display("row %h done", t.f7);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    @(posedge clk);
    ov_clear <= 1'b1;
    @(posedge clk);
    ov_clear <= 1'b0;
    #1 chk("cleared", overflow_sticky_flag, 1'b0);
    @(posedge clk);
    ov_clear <= 1'b1;
    run(rows[4]);
    @(posedge clk);
    ov_clear <= 1'b0;
    rst_b <= 1'b0;
    @(posedge clk);
    #1 chk("reset wb_valid", wb_valid, 1'b0);
    chk("reset flag", overflow_sticky_flag, 1'b0);
    chk("reset pulse", ov_set_pulse, 1'b0);
    chk("reset wb_data", wb_data, 64'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    run(rows[2]);
    $display("clear and reset done");
    test_done();
  end
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule // test_smac_unit
`default_nettype wire
